/* include/qip_pkg.sv */
// Constants shared by the quadrature index position block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package qip_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_INT_STS  = 8'h08;
    localparam logic [7:0] OFF_INT_MASK = 8'h0C;
    localparam logic [7:0] OFF_POSITION = 8'h10;
    localparam logic [7:0] OFF_POS_MAX  = 8'h14;
    localparam logic [7:0] OFF_POS_INIT = 8'h18;

    // Control fields
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_IEI_BIT = 3;
    localparam int CTRL_W       = 4;
    localparam logic [1:0] SEL_INDEX = 2'h0;

    // Status fields
    localparam int STS_FIRST_BIT = 0;
    localparam int STS_FDIR_BIT  = 1;
    localparam int STS_DIR_BIT   = 2;

    // Interrupt status and mask fields
    localparam int INT_INDEX_BIT  = 0;
    localparam int INT_DIRCHG_BIT = 1;
    localparam int INT_ERR_BIT    = 2;
    localparam int INT_W          = 3;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [31:0]       MAX_RST  = 32'hFFFFFFFF;
    localparam logic [31:0]       INIT_RST = 32'h00000000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : qip_pkg

/* src/qip_quad_dec.sv */
// Quadrature edge and direction decoder.
// Assumes phase inputs already synchronised to clk_i.
`timescale 1ns/1ps
module qip_quad_dec (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       ce_i,
    input  wire logic       a_i,
    input  wire logic       b_i,
    output logic            edge_o,
    output logic            fwd_o,
    output logic            err_o,
    output logic [1:0]      ab_o
);
    logic [1:0] prev_ff;
    logic [1:0] nxt_prev_ff;
    logic [1:0] cur;

    assign cur = {a_i, b_i};

    always_comb
    begin
        nxt_prev_ff = ce_i ? cur : prev_ff;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            prev_ff <= 2'h0;
        else
            prev_ff <= nxt_prev_ff;
    end

    // One phase changing is a count, both at once is a lost edge
    assign edge_o = ce_i && ((prev_ff ^ cur) == 2'h1
                             || (prev_ff ^ cur) == 2'h2);
    assign err_o  = ce_i && ((prev_ff ^ cur) == 2'h3);
    // B leading A is forward
    assign fwd_o  = prev_ff[1] ^ cur[0];
    assign ab_o   = cur;

endmodule : qip_quad_dec

/* src/qip_sync2.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes levels that may change at any time relative to clk_i.
`timescale 1ns/1ps
module qip_sync2 #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta_ff;
    logic [WIDTH-1:0] nxt_sync_ff;

    // First stage feeds only the second stage
    always_comb
    begin
        nxt_meta_ff = ce_i ? d_i : meta_ff;
        nxt_sync_ff = ce_i ? meta_ff : sync_ff;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta_ff;
            sync_ff <= nxt_sync_ff;
        end
    end

    assign q_o = sync_ff;

endmodule : qip_sync2

/* src/qip_top.sv */
// Position counter with index reset for an incremental quadrature encoder.
// Assumes encoder pins from outside the clock domain and an AXI4-Lite master.
//
// Summary of operation
// [R1] Select 00 resets count on index events
// [R2] Forward index event clears count to zero
// [R3] Reverse index event loads maximum position
// [R4] Latch first index seen and its direction
// [R5] Reuse first-index quadrature edge for resets
// [R6] Reversal during index may reset count wrongly
// [R7] Next clean index event resets correctly again
// [R8] Software avoids select 00 if reversals matter
// [R9] Inputs asynchronous; never bypass input synchronisation
// [R10] Decoder logic reads only synchronised inputs
// [R11] Count up forward, down reverse per edge
`timescale 1ns/1ps
module qip_top #(
    parameter int POS_W = 32
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             ce_i,
    input  wire logic             enc_a_i,
    input  wire logic             enc_b_i,
    input  wire logic             enc_index_i,
    input  wire logic [7:0]       s_axi_awaddr_i,
    input  wire logic             s_axi_awvalid_i,
    output logic                  s_axi_awready_o,
    input  wire logic [31:0]      s_axi_wdata_i,
    input  wire logic [3:0]       s_axi_wstrb_i,
    input  wire logic             s_axi_wvalid_i,
    output logic                  s_axi_wready_o,
    output logic [1:0]            s_axi_bresp_o,
    output logic                  s_axi_bvalid_o,
    input  wire logic             s_axi_bready_i,
    input  wire logic [7:0]       s_axi_araddr_i,
    input  wire logic             s_axi_arvalid_i,
    output logic                  s_axi_arready_o,
    output logic [31:0]           s_axi_rdata_o,
    output logic [1:0]            s_axi_rresp_o,
    output logic                  s_axi_rvalid_o,
    input  wire logic             s_axi_rready_i,
    output logic [POS_W-1:0]      position_count_o,
    output logic                  direction_o,
    output logic                  irq_o
);
    import qip_pkg::*;

    function automatic logic [31:0] apply_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction : apply_strb

    // Pin synchronisation and decoding
    logic [2:0] pins_sync;
    logic       q_edge;
    logic       q_fwd;
    logic       q_err;
    logic [1:0] q_ab;

    qip_sync2 #(
        .WIDTH (3)
    ) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .d_i      ({enc_a_i, enc_b_i, enc_index_i}),
        .q_o      (pins_sync)
    ); // [R10]

    qip_quad_dec u_dec (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .a_i      (pins_sync[2]),
        .b_i      (pins_sync[1]),
        .edge_o   (q_edge),
        .fwd_o    (q_fwd),
        .err_o    (q_err),
        .ab_o     (q_ab)
    ); // [R11]

    // Bus slave state
    logic              aw_held_ff,  nxt_aw_held_ff;
    logic [7:0]        aw_addr_ff,  nxt_aw_addr_ff;
    logic              w_held_ff,   nxt_w_held_ff;
    logic [31:0]       w_data_ff,   nxt_w_data_ff;
    logic [3:0]        w_strb_ff,   nxt_w_strb_ff;
    logic              bvalid_ff,   nxt_bvalid_ff;
    logic [1:0]        bresp_ff,    nxt_bresp_ff;
    logic              rvalid_ff,   nxt_rvalid_ff;
    logic [31:0]       rdata_ff,    nxt_rdata_ff;
    logic [1:0]        rresp_ff,    nxt_rresp_ff;

    // Registers and block state
    logic [CTRL_W-1:0] ctrl_ff,     nxt_ctrl_ff;
    logic [POS_W-1:0]  max_ff,      nxt_max_ff;
    logic [POS_W-1:0]  init_ff,     nxt_init_ff;
    logic [POS_W-1:0]  pos_ff,      nxt_pos_ff;
    logic [INT_W-1:0]  int_sts_ff,  nxt_int_sts_ff;
    logic [INT_W-1:0]  int_mask_ff, nxt_int_mask_ff;
    logic              first_ff,    nxt_first_ff;
    logic              fdir_ff,     nxt_fdir_ff;
    logic [1:0]        ref_ab_ff,   nxt_ref_ab_ff;
    logic              armed_ff,    nxt_armed_ff;
    logic              dir_ff,      nxt_dir_ff;
    logic              idx_prev_ff, nxt_idx_prev_ff;

    logic              wr_fire;
    logic              rd_fire;
    logic [31:0]       wr_val;
    logic              idx_level;
    logic              idx_rise;
    logic              enabled;
    logic              idx_mode;
    logic              reset_hit;
    logic [INT_W-1:0]  int_set;
    logic [INT_W-1:0]  int_clr;
    logic              first_clr;
    logic [31:0]       rd_val;
    logic              rd_ok;

    assign idx_level = pins_sync[0];
    assign idx_rise  = ce_i && idx_level && !idx_prev_ff;
    assign enabled   = ctrl_ff[CTRL_EN_BIT];
    assign idx_mode  = ctrl_ff[CTRL_SEL_LSB +: 2] == SEL_INDEX; // [R1]

    // Handshakes stall while the clock enable is low
    assign s_axi_awready_o = ce_i && !aw_held_ff && !bvalid_ff;
    assign s_axi_wready_o  = ce_i && !w_held_ff && !bvalid_ff;
    assign s_axi_arready_o = ce_i && !rvalid_ff;
    assign wr_fire = ce_i && aw_held_ff && w_held_ff && !bvalid_ff;
    assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
    assign wr_val  = w_data_ff;

    // A reset needs an armed index pulse and, once the first index has
    // been seen, the stored AB state. Direction is not rechecked, so a
    // reversal inside the pulse hits the wrong edge; kept as in silicon.
    assign reset_hit = enabled && idx_mode && armed_ff && idx_level
                       && q_edge
                       && (!first_ff || q_ab == ref_ab_ff); // [R5] [R6]

    // Read mux
    always_comb
    begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b1;
        case (s_axi_araddr_i)
            OFF_CTRL:     rd_val[CTRL_W-1:0] = ctrl_ff;
            OFF_STATUS:
            begin
                rd_val[STS_FIRST_BIT] = first_ff;
                rd_val[STS_FDIR_BIT]  = fdir_ff;
                rd_val[STS_DIR_BIT]   = dir_ff;
            end
            OFF_INT_STS:  rd_val[INT_W-1:0] = int_sts_ff;
            OFF_INT_MASK: rd_val[INT_W-1:0] = int_mask_ff;
            OFF_POSITION: rd_val[POS_W-1:0] = pos_ff;
            OFF_POS_MAX:  rd_val[POS_W-1:0] = max_ff;
            OFF_POS_INIT: rd_val[POS_W-1:0] = init_ff;
            default:      rd_ok = 1'b0;
        endcase
    end

    // Bus channel next state
    always_comb
    begin
        nxt_aw_held_ff = aw_held_ff;
        nxt_aw_addr_ff = aw_addr_ff;
        nxt_w_held_ff  = w_held_ff;
        nxt_w_data_ff  = w_data_ff;
        nxt_w_strb_ff  = w_strb_ff;
        nxt_bvalid_ff  = bvalid_ff;
        nxt_bresp_ff   = bresp_ff;
        nxt_rvalid_ff  = rvalid_ff;
        nxt_rdata_ff   = rdata_ff;
        nxt_rresp_ff   = rresp_ff;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            nxt_aw_held_ff = 1'b1;
            nxt_aw_addr_ff = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            nxt_w_held_ff = 1'b1;
            nxt_w_data_ff = s_axi_wdata_i;
            nxt_w_strb_ff = s_axi_wstrb_i;
        end
        if (wr_fire)
        begin
            nxt_aw_held_ff = 1'b0;
            nxt_w_held_ff  = 1'b0;
            nxt_bvalid_ff  = 1'b1;
            case (aw_addr_ff)
                OFF_CTRL, OFF_STATUS, OFF_INT_STS, OFF_INT_MASK,
                OFF_POSITION, OFF_POS_MAX, OFF_POS_INIT:
                    nxt_bresp_ff = RESP_OKAY;
                default:
                    nxt_bresp_ff = RESP_SLVERR;
            endcase
        end
        else if (ce_i && bvalid_ff && s_axi_bready_i)
            nxt_bvalid_ff = 1'b0;
        if (rd_fire)
        begin
            nxt_rvalid_ff = 1'b1;
            nxt_rdata_ff  = rd_val;
            nxt_rresp_ff  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (ce_i && rvalid_ff && s_axi_rready_i)
            nxt_rvalid_ff = 1'b0;
    end

    // Register and counter next state
    always_comb
    begin
        nxt_ctrl_ff     = ctrl_ff;
        nxt_max_ff      = max_ff;
        nxt_init_ff     = init_ff;
        nxt_pos_ff      = pos_ff;
        nxt_int_mask_ff = int_mask_ff;
        nxt_first_ff    = first_ff;
        nxt_fdir_ff     = fdir_ff;
        nxt_ref_ab_ff   = ref_ab_ff;
        nxt_armed_ff    = armed_ff;
        nxt_dir_ff      = dir_ff;
        nxt_idx_prev_ff = ce_i ? idx_level : idx_prev_ff;
        int_clr         = '0;
        first_clr       = 1'b0;
        int_set         = '0;

        if (wr_fire)
        begin
            case (aw_addr_ff)
                OFF_CTRL:
                    nxt_ctrl_ff = CTRL_W'(apply_strb(
                        32'(ctrl_ff), wr_val, w_strb_ff));
                OFF_STATUS:
                    first_clr = w_strb_ff[0] && wr_val[STS_FIRST_BIT];
                OFF_INT_STS:
                    int_clr = w_strb_ff[0] ? wr_val[INT_W-1:0] : '0;
                OFF_INT_MASK:
                    nxt_int_mask_ff = INT_W'(apply_strb(
                        32'(int_mask_ff), wr_val, w_strb_ff));
                OFF_POS_MAX:
                    nxt_max_ff = POS_W'(apply_strb(
                        32'(max_ff), wr_val, w_strb_ff));
                OFF_POS_INIT:
                    nxt_init_ff = POS_W'(apply_strb(
                        32'(init_ff), wr_val, w_strb_ff));
                default: ;
            endcase
        end

        if (first_clr)
        begin
            nxt_first_ff = 1'b0;
            nxt_fdir_ff  = 1'b0;
        end

        if (enabled && ce_i)
        begin
            if (q_edge)
                nxt_dir_ff = q_fwd;
            // One reset per index pulse; dropped when the pulse ends
            if (idx_rise)
                nxt_armed_ff = 1'b1;
            else if (reset_hit || !idx_level)
                nxt_armed_ff = 1'b0;
            // Latch wins over a same-cycle software clear
            if (reset_hit && !first_ff)
            begin
                nxt_first_ff  = 1'b1; // [R4]
                nxt_fdir_ff   = q_fwd; // [R4]
                nxt_ref_ab_ff = q_ab; // [R5]
            end
            if (q_edge)
            begin
                if (q_fwd)
                    nxt_pos_ff = (pos_ff == max_ff) ? '0 : pos_ff + 1'b1;
                else
                    nxt_pos_ff = (pos_ff == '0) ? max_ff : pos_ff - 1'b1;
            end // [R11]
            // Replaces the count of the same edge; next edge clean again
            if (reset_hit)
                nxt_pos_ff = q_fwd ? '0 : max_ff; // [R2] [R3] [R7]
            if (idx_rise && ctrl_ff[CTRL_IEI_BIT])
                nxt_pos_ff = init_ff;
            int_set[INT_INDEX_BIT]  = idx_rise;
            int_set[INT_DIRCHG_BIT] = q_edge && (q_fwd != dir_ff);
            int_set[INT_ERR_BIT]    = q_err;
        end

        // Software load of the count has top priority
        if (wr_fire && aw_addr_ff == OFF_POSITION)
            nxt_pos_ff = POS_W'(apply_strb(
                32'(pos_ff), wr_val, w_strb_ff));

        // Set wins over write-one-to-clear
        nxt_int_sts_ff = (int_sts_ff & ~int_clr) | int_set;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_held_ff  <= 1'b0;
            aw_addr_ff  <= 8'h00;
            w_held_ff   <= 1'b0;
            w_data_ff   <= 32'h00000000;
            w_strb_ff   <= 4'h0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= RESP_OKAY;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h00000000;
            rresp_ff    <= RESP_OKAY;
            ctrl_ff     <= CTRL_RST;
            max_ff      <= MAX_RST[POS_W-1:0];
            init_ff     <= INIT_RST[POS_W-1:0];
            pos_ff      <= '0;
            int_sts_ff  <= '0;
            int_mask_ff <= '0;
            first_ff    <= 1'b0;
            fdir_ff     <= 1'b0;
            ref_ab_ff   <= 2'h0;
            armed_ff    <= 1'b0;
            dir_ff      <= 1'b0;
            idx_prev_ff <= 1'b0;
        end
        else
        begin
            aw_held_ff  <= nxt_aw_held_ff;
            aw_addr_ff  <= nxt_aw_addr_ff;
            w_held_ff   <= nxt_w_held_ff;
            w_data_ff   <= nxt_w_data_ff;
            w_strb_ff   <= nxt_w_strb_ff;
            bvalid_ff   <= nxt_bvalid_ff;
            bresp_ff    <= nxt_bresp_ff;
            rvalid_ff   <= nxt_rvalid_ff;
            rdata_ff    <= nxt_rdata_ff;
            rresp_ff    <= nxt_rresp_ff;
            ctrl_ff     <= nxt_ctrl_ff;
            max_ff      <= nxt_max_ff;
            init_ff     <= nxt_init_ff;
            pos_ff      <= nxt_pos_ff;
            int_sts_ff  <= nxt_int_sts_ff;
            int_mask_ff <= nxt_int_mask_ff;
            first_ff    <= nxt_first_ff;
            fdir_ff     <= nxt_fdir_ff;
            ref_ab_ff   <= nxt_ref_ab_ff;
            armed_ff    <= nxt_armed_ff;
            dir_ff      <= nxt_dir_ff;
            idx_prev_ff <= nxt_idx_prev_ff;
        end
    end

    assign s_axi_bvalid_o   = bvalid_ff;
    assign s_axi_bresp_o    = bresp_ff;
    assign s_axi_rvalid_o   = rvalid_ff;
    assign s_axi_rdata_o    = rdata_ff;
    assign s_axi_rresp_o    = rresp_ff;
    assign position_count_o = pos_ff;
    assign direction_o      = dir_ff;
    assign irq_o            = |(int_sts_ff & int_mask_ff);

endmodule : qip_top

/* verification/qip_checker.sv */
// Port timing checks for the quadrature index position block.
// Assumes binding into qip_top; sees its ports only.
`timescale 1ns/1ps
module qip_checker #(
    parameter int POS_W = 32
) (
    input wire logic             clk_i,
    input wire logic             arst_n_i,
    input wire logic             ce_i,
    input wire logic             s_axi_awvalid_i,
    input wire logic             s_axi_awready_o,
    input wire logic             s_axi_wvalid_i,
    input wire logic             s_axi_wready_o,
    input wire logic [1:0]       s_axi_bresp_o,
    input wire logic             s_axi_bvalid_o,
    input wire logic             s_axi_bready_i,
    input wire logic             s_axi_arvalid_i,
    input wire logic             s_axi_arready_o,
    input wire logic [31:0]      s_axi_rdata_o,
    input wire logic             s_axi_rvalid_o,
    input wire logic             s_axi_rready_i,
    input wire logic [POS_W-1:0] position_count_o,
    input wire logic             direction_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
            && s_axi_wready_o;
    endsequence
    sequence s_wr_answer;
        ##[1:2] s_axi_bvalid_o;
    endsequence
    chk_write_answer: assert property (s_wr_taken |-> s_wr_answer)
        else $error("write response late");
    chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o)
        else $error("read data late");
    chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    chk_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while answer pending");
    chk_write_block: assert property (s_axi_bvalid_o
        |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    chk_ce_freeze: assert property (!ce_i
        |=> $stable(position_count_o) && $stable(direction_o))
        else $error("count moved with clock enable low");
    // Writes land at the edge where the response rises, so skip those
    chk_fwd_step: assert property (
        $changed(position_count_o) && direction_o
        && $past(direction_o) && !$rose(s_axi_bvalid_o)
        |-> position_count_o == $past(position_count_o) + 1'h1
            || position_count_o == 0)
        else $error("forward count step wrong");
endmodule : qip_checker

bind qip_top qip_checker #(.POS_W(POS_W)) u_qip_checker (.clk_i, .arst_n_i,
    .ce_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .position_count_o, .direction_o);

/* verification/qip_enc_model.sv */
// Incremental encoder with index output, behavioural.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/1ps
module qip_enc_model (
    input  wire logic clk_i,
    output logic      a_o,
    output logic      b_o,
    output logic      idx_o
);
    initial
    begin
        a_o = 1'h0;
        b_o = 1'h0;
        idx_o = 1'h0;
    end
    // Pins move just after a system edge, never asynchronously
    task automatic step(input bit fwd);
        @(posedge clk_i);
        a_o <= fwd ? b_o : ~b_o;
        b_o <= fwd ? ~a_o : a_o;
    endtask : step
    task automatic index(input bit lvl);
        @(posedge clk_i);
        idx_o <= lvl;
    endtask : index
endmodule : qip_enc_model

/* verification/qip_top_tb_top.sv */
// Self-checking bench for the quadrature index position block.
// Assumes the encoder model and the bound checker beside it.
`timescale 1ns/1ps
module qip_top_tb_top;
    import qip_pkg::*;
    logic        clk_i = 1'h0, arst_n_i = 1'h0, ce_i = 1'h1;
    logic        enc_a_i, enc_b_i, enc_index_i, direction_o, irq_o;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, position_count_o;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
    logic        s_axi_arvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic        s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, m_ab = 2'h0, m_sab, m_sel;
    logic [31:0] rs = 32'hE576D6E8, m_cnt = 32'h0, m_max, m_init, t;
    bit          m_first, m_arm, m_idx, m_iei;
    int          miscompares = 0, check_count = 0;

    always #2.5 clk_i = ~clk_i;

    qip_top u_qip_top (.clk_i, .arst_n_i, .ce_i, .enc_a_i, .enc_b_i,
        .enc_index_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .position_count_o, .direction_o,
        .irq_o);
    qip_enc_model u_qip_enc_model (.clk_i, .a_o(enc_a_i), .b_o(enc_b_i),
        .idx_o(enc_index_i));

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_awready_o)
                s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o)
                s_axi_wvalid_i <= 1'h0;
        end while (s_axi_bvalid_o !== 1'h1);
        // Late ready lets the response be seen holding
        s_axi_bready_i <= 1'h1;
        @(posedge clk_i);
        s_axi_bready_i <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 1'h0;
        end while (s_axi_rvalid_o !== 1'h1);
        s_axi_rready_i <= 1'h1;
        @(posedge clk_i);
        s_axi_rready_i <= 1'h0;
        chk("rdata", ed, s_axi_rdata_o);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
    endtask : rd

    task automatic cfg(input logic [1:0] sel, input bit index_event_init);
        m_sel = sel;
        m_iei = index_event_init;
        wr(OFF_CTRL, {28'h0, index_event_init, sel, 1'h1}, RESP_OKAY);
    endtask : cfg

    // Reference model of one quadrature edge; h expects a frozen count
    task automatic mv(input bit f, input bit h = 1'h0);
        logic [31:0] old;
        old = m_cnt;
        m_ab = f ? {m_ab[0], ~m_ab[1]} : {~m_ab[0], m_ab[1]};
        if (m_sel == 2'h0 && m_idx && m_arm && (!m_first || m_ab == m_sab))
        begin
            m_cnt = f ? 32'h0 : m_max;
            m_arm = 1'h0;
            if (!m_first)
                m_sab = m_ab;
            m_first = 1'h1;
        end
        else if (f)
            m_cnt = (m_cnt == m_max) ? 32'h0 : m_cnt + 32'h1;
        else
            m_cnt = (m_cnt == 32'h0) ? m_max : m_cnt - 32'h1;
        u_qip_enc_model.step(f);
        repeat (6) @(posedge clk_i);
        chk("count", h ? old : m_cnt, position_count_o);
        if (!h)
            chk("direction", {31'h0, f}, {31'h0, direction_o});
    endtask : mv

    task automatic ix(input bit v);
        if (v && !m_idx)
            m_arm = 1'h1;
        if (v && !m_idx && m_iei)
            m_cnt = m_init;
        m_idx = v;
        u_qip_enc_model.index(v);
        repeat (6) @(posedge clk_i);
        chk("count", m_cnt, position_count_o);
    endtask : ix

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial
    begin
        #100000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'h1;
        rd(OFF_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_POS_MAX, MAX_RST, RESP_OKAY);
        rd(8'h1C, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'h5, RESP_SLVERR);
        m_max = 32'h8 + (rnd() & 32'hF);
        wr(OFF_POS_MAX, m_max, RESP_OKAY);
        cfg(2'h1, 1'h0);
        repeat (40)
        begin
            t = rnd();
            mv(t[0]);
        end
        rd(OFF_POSITION, m_cnt, RESP_OKAY);
        m_cnt = 32'h5;
        wr(OFF_POSITION, m_cnt, RESP_OKAY);
        cfg(SEL_INDEX, 1'h0);
        ix(1'h1);
        mv(1'h1);
        rd(OFF_STATUS, 32'h7, RESP_OKAY);
        wr(OFF_STATUS, 32'h1, RESP_OKAY);
        m_first = 1'h0;
        rd(OFF_STATUS, 32'h4, RESP_OKAY);
        ix(1'h0);
        repeat (3) mv(1'h1);
        ix(1'h1);
        repeat (4) mv(1'h0);
        ix(1'h0);
        // Reversal inside the pulse, then a clean pulse
        ix(1'h1);
        mv(1'h1);
        repeat (3) mv(1'h0);
        ix(1'h0);
        ix(1'h1);
        repeat (4) mv(1'h0);
        ix(1'h0);
        cfg(2'h1, 1'h0);
        wr(OFF_INT_STS, 32'h7, RESP_OKAY);
        wr(OFF_INT_MASK, 32'h1, RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq_o});
        ix(1'h1);
        chk("irq", 32'h1, {31'h0, irq_o});
        ix(1'h0);
        rd(OFF_INT_STS, 32'h1, RESP_OKAY);
        wr(OFF_INT_STS, 32'h1, RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(OFF_INT_MASK, 32'h0, RESP_OKAY);
        ix(1'h1);
        ix(1'h0);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(OFF_INT_MASK, 32'h1, RESP_OKAY);
        chk("irq", 32'h1, {31'h0, irq_o});
        wr(OFF_INT_STS, 32'h7, RESP_OKAY);
        ce_i <= 1'h0;
        mv(1'h1, 1'h1);
        ce_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        chk("count", m_cnt, position_count_o);
        mv(1'h0);
        m_init = rnd() & 32'h7;
        wr(OFF_POS_INIT, m_init, RESP_OKAY);
        cfg(2'h1, 1'h1);
        ix(1'h1);
        ix(1'h0);
        print_verdict();
    end
endmodule : qip_top_tb_top
